// ---- common/dsw_pkg.sv ----
// shared constants and carrier types of the data space window logic
package dsw_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int DATA_W      = 8;
  localparam int ADDR_W      = 8;
  localparam int OFS_W       = 6;
  localparam int WIN_W       = 7;
  localparam int ROM_ADDR_W  = WIN_W + OFS_W;
  localparam int EE_PAGE_W   = 3;
  localparam int EE_ADDR_W   = EE_PAGE_W + OFS_W;
  localparam int RAM_PAGE_W  = 2;
  localparam int RAM_ADDR_W  = RAM_PAGE_W + OFS_W;

  // ---------------------------------------------------------------
  // data space areas, selected by address bits 7:6
  // ---------------------------------------------------------------
  localparam logic [1:0] AREA_BANKED  = 2'h0;  // 00h..3fh
  localparam logic [1:0] AREA_ROM_WIN = 2'h1;  // 40h..7fh
  localparam logic [1:0] AREA_RAM_DIR = 2'h2;  // 80h..bfh
  localparam logic [1:0] AREA_REGS    = 2'h3;  // c0h..ffh

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ROM_WINDOW_BASE_OFS  = 8'hc9;
  localparam logic [ADDR_W-1:0] BANK_PAGE_SELECT_OFS = 8'he8;

  // ---------------------------------------------------------------
  // bank select fields
  // ---------------------------------------------------------------
  localparam int EE_LO_BIT     = 0;
  localparam int EE_HI_BIT     = 1;
  localparam int EE_UPPER_BIT  = 7;
  localparam int RAM_FIRST_BIT = 2;
  localparam int RAM_BANKS     = 3;
  localparam logic [EE_PAGE_W-1:0] EE_UPPER_PAGE0 = 3'h3;

  // direct ram sits in array page 0, banked ram pages 2..4 in 1..3
  localparam logic [RAM_PAGE_W-1:0] RAM_DIR_PAGE = 2'h0;

  // ---------------------------------------------------------------
  // reset and idle values
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] RDATA_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_NONE   = 8'h00;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } dsw_bus_req_t;

  typedef struct packed {
    logic [EE_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]    wdata;
    logic                 wr;
    logic                 rd;
  } dsw_ee_req_t;

  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_RAM,
    SRC_ROM,
    SRC_EE
  } dsw_src_t;

endpackage

// ---- logic/dsw_data_window.sv ----
// data space address translation: rom window, direct ram, banked area
//
// Functional notes
// - addresses 40h..7fh read program rom bytes, writes there ignored
// - writing c9h moves the rom window in 64-byte steps
// - rom address is window base above the low six address bits
// - window base holds seven bits, the upper rom address bits
// - window base has no reset value
// - window base is write-only, reads return zero
// - 64 bytes of ram sit unbanked at 80h..bfh
// - extra ram and eeprom reached only as 64-byte banks at 00h..3fh
// - bank select register at e8h picks the banked page
// - every rom byte may be code or window data
// - bits 0,1,7 pick eeprom pages 0..5 (01..03h, 81..83h)
// - bits 2,3,4 map ram pages 2,3,4 (04h, 08h, 10h)
// - bank select is write-only and has no reset value
`timescale 1ns/1ps

module dsw_data_window #(
  parameter int RAM_BYTES = 256
) (
  input  wire logic                          MCLK,
  input  wire logic                          RESET,
  input  wire logic                          CE,
  input  wire dsw_pkg::dsw_bus_req_t         BUS_REQ,
  output logic [dsw_pkg::DATA_W-1:0]         RDATA,
  output logic [dsw_pkg::ROM_ADDR_W-1:0]     ROM_ADDR,
  input  wire logic [dsw_pkg::DATA_W-1:0]    ROM_DATA,
  output dsw_pkg::dsw_ee_req_t               EE_REQ,
  input  wire logic [dsw_pkg::DATA_W-1:0]    EE_RDATA,
  output logic                               BANK_NONE
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [dsw_pkg::WIN_W-1:0]  rom_window_upper_bits_q;
  logic [dsw_pkg::DATA_W-1:0] bank_page_select_q;
  logic [dsw_pkg::DATA_W-1:0] ram_mem [RAM_BYTES];
  logic [dsw_pkg::DATA_W-1:0] rdata_q;
  logic                       bank_none_q;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic [1:0]                     area;
  logic [dsw_pkg::OFS_W-1:0]      ofs;
  logic                           wr_en;
  logic                           rd_en;
  logic [dsw_pkg::RAM_BANKS-1:0]  ram_bit;
  logic [1:0]                     ee_sel;
  logic                           ee_hit;
  logic                           ram_bank_hit;
  logic [dsw_pkg::RAM_PAGE_W-1:0] ram_bank_page;
  logic [dsw_pkg::EE_PAGE_W-1:0]  ee_page;
  logic                           ram_acc;
  logic [dsw_pkg::RAM_PAGE_W-1:0] ram_page;
  logic [dsw_pkg::RAM_ADDR_W-1:0] ram_addr;
  logic                           ee_acc;
  dsw_pkg::dsw_src_t              src;

  assign area  = BUS_REQ.addr[7:6];
  assign ofs   = BUS_REQ.addr[dsw_pkg::OFS_W-1:0];
  assign wr_en = CE & BUS_REQ.wr;
  assign rd_en = CE & BUS_REQ.rd;

  assign ee_sel = {bank_page_select_q[dsw_pkg::EE_HI_BIT],
                   bank_page_select_q[dsw_pkg::EE_LO_BIT]};
  assign ee_hit = (ee_sel != 2'h0);

  // one enable bit per extra ram page
  genvar gi;
  generate
    for (gi = 0; gi < dsw_pkg::RAM_BANKS; gi = gi + 1)
    begin : g_ram_bit
      assign ram_bit[gi] =
        bank_page_select_q[dsw_pkg::RAM_FIRST_BIT + gi];
    end
  endgenerate

  // eeprom wins over ram, then lowest ram bit; only matters when
  // software breaks the one-bank convention
  always_comb
  begin
    ram_bank_hit  = 1'b1;
    ram_bank_page = 2'h1;
    if (ram_bit[0])
    begin
      ram_bank_page = 2'h1;
    end
    else if (ram_bit[1])
    begin
      ram_bank_page = 2'h2;
    end
    else if (ram_bit[2])
    begin
      ram_bank_page = 2'h3;
    end
    else
    begin
      ram_bank_hit = 1'b0;
    end
  end

  // pages 0..2 from 01h..03h, bit 7 adds three
  always_comb
  begin
    ee_page = {1'b0, ee_sel} - 3'h1;
    if (bank_page_select_q[dsw_pkg::EE_UPPER_BIT])
    begin
      ee_page = ee_page + dsw_pkg::EE_UPPER_PAGE0;
    end
  end

  // ---------------------------------------------------------------
  // area routing
  // ---------------------------------------------------------------
  always_comb
  begin
    ram_acc  = 1'b0;
    ram_page = dsw_pkg::RAM_DIR_PAGE;
    ee_acc   = 1'b0;
    src      = dsw_pkg::SRC_NONE;
    case (area)
      dsw_pkg::AREA_BANKED:
      begin
        if (ee_hit)
        begin
          ee_acc = 1'b1;
          src    = dsw_pkg::SRC_EE;
        end
        else if (ram_bank_hit)
        begin
          ram_acc  = 1'b1;
          ram_page = ram_bank_page;
          src      = dsw_pkg::SRC_RAM;
        end
      end
      dsw_pkg::AREA_ROM_WIN:
      begin
        src = dsw_pkg::SRC_ROM;
      end
      dsw_pkg::AREA_RAM_DIR:
      begin
        ram_acc = 1'b1;
        src     = dsw_pkg::SRC_RAM;
      end
      default:
      begin
        // fixed registers belong to other blocks; both ours read 0
        src = dsw_pkg::SRC_NONE;
      end
    endcase
  end

  assign ram_addr = {ram_page, ofs};

  // ---------------------------------------------------------------
  // translated addresses
  // ---------------------------------------------------------------
  // rom and eeprom answer combinationally so data lands in rdata_q
  // one cycle after the strobe, as the core bus expects
  assign ROM_ADDR = {rom_window_upper_bits_q, ofs};

  always_comb
  begin
    EE_REQ.addr  = {ee_page, ofs};
    EE_REQ.wdata = BUS_REQ.wdata;
    EE_REQ.wr    = wr_en & ee_acc;
    EE_REQ.rd    = rd_en & ee_acc;
  end

  // ---------------------------------------------------------------
  // write-only registers, deliberately without reset
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (wr_en && BUS_REQ.addr == dsw_pkg::ROM_WINDOW_BASE_OFS)
    begin
      // upper data bit has no storage
      rom_window_upper_bits_q <=
        BUS_REQ.wdata[dsw_pkg::WIN_W-1:0];
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (wr_en && BUS_REQ.addr == dsw_pkg::BANK_PAGE_SELECT_OFS)
    begin
      bank_page_select_q <= BUS_REQ.wdata;
    end
  end

  // ---------------------------------------------------------------
  // ram array
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (wr_en && ram_acc)
    begin
      ram_mem[ram_addr] <= BUS_REQ.wdata;
    end
  end

  // ---------------------------------------------------------------
  // read data, valid from the cycle after the read strobe until the next enabled cycle
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      rdata_q <= dsw_pkg::RDATA_RESET;
    end
    else if (CE)
    begin
      if (BUS_REQ.rd)
      begin
        case (src)
          dsw_pkg::SRC_RAM: rdata_q <= ram_mem[ram_addr];
          dsw_pkg::SRC_ROM: rdata_q <= ROM_DATA;
          dsw_pkg::SRC_EE:  rdata_q <= EE_RDATA;
          default:          rdata_q <= dsw_pkg::READ_NONE;
        endcase
      end
      else
      begin
        rdata_q <= dsw_pkg::READ_NONE;
      end
    end
  end

  // flags that the banked area currently maps nothing
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      bank_none_q <= 1'b1;
    end
    else if (CE)
    begin
      bank_none_q <= ~(ee_hit | ram_bank_hit);
    end
  end

  assign RDATA     = rdata_q;
  assign BANK_NONE = bank_none_q;

endmodule

// ---- test/dsw_mem_model.sv ----
// rom and eeprom model on the far side of the window logic
`timescale 1ns/1ps
module dsw_mem_model (
  input  wire logic                           mclk,
  input  wire logic [dsw_pkg::ROM_ADDR_W-1:0] rom_addr,
  output logic [dsw_pkg::DATA_W-1:0]          rom_data,
  input  wire dsw_pkg::dsw_ee_req_t           ee_req,
  output logic [dsw_pkg::DATA_W-1:0]          ee_rdata
);
  logic [dsw_pkg::DATA_W-1:0] ee_q [0:511];
  // a pattern stands in for code and tables alike
  assign rom_data = rom_addr[7:0] ^ {3'h0, rom_addr[12:8]} ^ 8'h5a;
  // async read, data needed in the access cycle
  assign ee_rdata = ee_q[ee_req.addr];
  always_ff @(posedge mclk)
  begin
    if (ee_req.wr)
      ee_q[ee_req.addr] <= ee_req.wdata;
  end
endmodule

// ---- test/dsw_monitor.sv ----
// assertion checker for the data space window logic
`timescale 1ns/1ps
module dsw_monitor (
  input wire logic                           MCLK,
  input wire logic                           RESET,
  input wire logic                           CE,
  input wire dsw_pkg::dsw_bus_req_t          BUS_REQ,
  input wire logic [dsw_pkg::DATA_W-1:0]     RDATA,
  input wire logic [dsw_pkg::ROM_ADDR_W-1:0] ROM_ADDR,
  input wire logic [dsw_pkg::DATA_W-1:0]     ROM_DATA,
  input wire dsw_pkg::dsw_ee_req_t           EE_REQ,
  input wire logic [dsw_pkg::DATA_W-1:0]     EE_RDATA,
  input wire logic                           BANK_NONE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  logic       rd_c;
  logic       wr_c;
  logic [1:0] area;
  assign rd_c = CE && BUS_REQ.rd;
  assign wr_c = CE && BUS_REQ.wr;
  assign area = BUS_REQ.addr[7:6];
  // ----
  // properties
  // ----
  property p_rom_low;
    ROM_ADDR[5:0] == BUS_REQ.addr[5:0];
  endproperty
  a_rom_low: assert property (p_rom_low)
    else $error("rom address low bits differ from bus");
  property p_rom_base;
    wr_c && BUS_REQ.addr == dsw_pkg::ROM_WINDOW_BASE_OFS
      |=> ROM_ADDR[12:6] == $past(BUS_REQ.wdata[6:0]);
  endproperty
  a_rom_base: assert property (p_rom_base)
    else $error("window base not applied to rom address");
  property p_rom_rd;
    rd_c && area == dsw_pkg::AREA_ROM_WIN |=> RDATA == $past(ROM_DATA);
  endproperty
  a_rom_rd: assert property (p_rom_rd)
    else $error("window read data differs from rom byte");
  property p_wo;
    rd_c && BUS_REQ.addr inside {8'hc9, 8'he8} |=> RDATA == 8'h00;
  endproperty
  a_wo: assert property (p_wo)
    else $error("write-only register returned data");
  property p_idle;
    CE && !BUS_REQ.rd |=> RDATA == dsw_pkg::READ_NONE;
  endproperty
  a_idle: assert property (p_idle)
    else $error("read data present without a read");
  property p_ee_gate;
    EE_REQ.rd || EE_REQ.wr |-> area == dsw_pkg::AREA_BANKED
      && (EE_REQ.rd ? rd_c : wr_c) && !(EE_REQ.rd && EE_REQ.wr);
  endproperty
  a_ee_gate: assert property (p_ee_gate)
    else $error("eeprom strobe outside a banked access");
  property p_ee_fwd;
    EE_REQ.rd || EE_REQ.wr |-> EE_REQ.addr[5:0] == BUS_REQ.addr[5:0]
      && EE_REQ.wdata == BUS_REQ.wdata;
  endproperty
  a_ee_fwd: assert property (p_ee_fwd)
    else $error("eeprom offset or data not forwarded");
  property p_ee_data;
    EE_REQ.rd |=> RDATA == $past(EE_RDATA);
  endproperty
  a_ee_data: assert property (p_ee_data)
    else $error("eeprom byte not returned");
  property p_none;
    wr_c && BUS_REQ.addr == dsw_pkg::BANK_PAGE_SELECT_OFS ##1 CE
      |=> BANK_NONE == ($past(BUS_REQ.wdata[4:0], 2) == 5'h00);
  endproperty
  a_none: assert property (p_none)
    else $error("bank mapped flag wrong after bank write");
  c_rom: cover property (rd_c && area == dsw_pkg::AREA_ROM_WIN);
  c_ee: cover property (EE_REQ.rd);
  c_bank: cover property (wr_c && BUS_REQ.addr == 8'he8);
endmodule

bind dsw_data_window dsw_monitor dsw_monitor_i (.MCLK, .RESET, .CE,
  .BUS_REQ, .RDATA, .ROM_ADDR, .ROM_DATA, .EE_REQ, .EE_RDATA, .BANK_NONE);

// ---- test/tb_top.sv ----
// self-checking bench for the data space window logic
`timescale 1ns/1ps
module tb_top;
  logic                  mclk;
  logic                  reset;
  logic                  ce;
  dsw_pkg::dsw_bus_req_t req;
  dsw_pkg::dsw_ee_req_t  ee;
  logic [7:0]            rdata;
  logic [7:0]            rom_d;
  logic [7:0]            ee_d;
  logic [12:0]           rom_a;
  logic                  bnone;
  int                    bad_count;
  int                    compares;
  logic [7:0]            wv [4] = '{8'h00, 8'h81, 8'h7f, 8'h2a};
  logic [7:0]            rp [3] = '{8'h04, 8'h08, 8'h10};
  logic [7:0] ev [6] = '{8'h01, 8'h02, 8'h03, 8'h81, 8'h82, 8'h83};
  dsw_data_window dsw_data_window_i (.MCLK(mclk), .RESET(reset), .CE(ce),
    .BUS_REQ(req), .RDATA(rdata), .ROM_ADDR(rom_a), .ROM_DATA(rom_d),
    .EE_REQ(ee), .EE_RDATA(ee_d), .BANK_NONE(bnone));
  dsw_mem_model dsw_mem_model_i (.mclk(mclk), .rom_addr(rom_a),
    .rom_data(rom_d), .ee_req(ee), .ee_rdata(ee_d));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ----
  // bus tasks
  // ----
  task automatic chk(string n, logic [12:0] s, logic [12:0] e);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    req <= '{a, d, 1'b1, 1'b0};
  endtask
  // strobe held one cycle, data checked in the cycle after
  task automatic rdc(logic [7:0] a, logic [7:0] e);
    @(posedge mclk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    req <= '0;
    #1;
    chk($sformatf("read %h", a), rdata, e);
  endtask
  function automatic logic [7:0] rom_exp(logic [6:0] b, logic [5:0] o);
    return {b[1:0], o} ^ {3'h0, b[6:2]} ^ 8'h5a;
  endfunction
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (2000) @(posedge mclk);
    bad_count++;
    report_and_stop();
  end
  initial
  begin
    bad_count = 0;
    compares = 0;
    req = '0;
    ce = 1'b1;
    reset = 1'b1;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    foreach (wv[i])
    begin
      wr(8'h90, wv[i]);
      wr(8'hc9, wv[i]);
      rdc({2'h1, 6'(i * 21)}, rom_exp(wv[i][6:0], 6'(i * 21)));
      chk("rom addr", rom_a, {wv[i][6:0], 6'h00});
    end
    wr(8'h45, 8'haa);
    rdc(8'h45, rom_exp(7'h2a, 6'h05));
    rdc(8'hc9, 8'h00);
    rdc(8'he8, 8'h00);
    $display("test window done");
    wr(8'he8, 8'h00);
    wr(8'h05, 8'h99);
    rdc(8'h05, 8'h00);
    chk("bank none", bnone, 1'b1);
    foreach (rp[i])
    begin
      wr(8'he8, rp[i]);
      wr(8'h3f, 8'h60 + 8'(i));
    end
    wr(8'hbf, 8'h77);
    wr(8'h80, 8'h66);
    foreach (rp[i])
    begin
      wr(8'he8, rp[i]);
      rdc(8'h3f, 8'h60 + 8'(i));
    end
    rdc(8'hbf, 8'h77);
    rdc(8'h80, 8'h66);
    chk("bank none", bnone, 1'b0);
    $display("test ram done");
    foreach (ev[i])
    begin
      wr(8'he8, ev[i]);
      wr(8'h10, 8'h30 + 8'(i));
    end
    foreach (ev[i])
    begin
      wr(8'he8, ev[i]);
      rdc(8'h10, 8'h30 + 8'(i));
      chk("ee page", dsw_mem_model_i.ee_q[{3'(i), 6'h10}], 8'h30 + 8'(i));
    end
    $display("test eeprom done");
    // clock enable low must freeze the window base
    @(posedge mclk);
    ce <= 1'b0;
    wr(8'hc9, 8'h11);
    @(posedge mclk);
    ce <= 1'b1;
    req <= '0;
    rdc(8'h45, rom_exp(7'h2a, 6'h05));
    chk("frozen base", rom_a, {7'h2a, 6'h00});
    $display("test enable done");
    report_and_stop();
  end
endmodule
